// File: ghb_host_if.sv
`timescale 1ns/1ns
module ghb_host_if (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic host_if_clock,
   input wire logic cs_n,
   input wire logic [ghb_pkg::ADDR_W-1:0] ctrl_address,
   input wire logic [ghb_pkg::DATA_W-1:0] ctrl_data_in,
   output logic [ghb_pkg::DATA_W-1:0] ctrl_data_out,
   output logic ctrl_data_oe_n,
   input wire logic low_byte_write_n,
   input wire logic high_byte_write_n,
   input wire logic low_byte_read_n,
   input wire logic high_byte_read_n,
   output logic wait_n,
   input wire logic [ghb_pkg::MODE_W-1:0] bus_mode_straps,
   input wire logic bus_status_n,
   input wire logic [1:0] endian_and_power_straps,
   input wire logic panel_power_on,
   output logic panel_power_out,
   output ghb_pkg::ghb_cfg_t cfg,
   output logic cfg_valid,
   output ghb_pkg::ghb_xfer_t mem_xfer,
   output logic mem_req,
   output logic mem_is_reg,
   input wire logic mem_gnt,
   input wire logic [ghb_pkg::DATA_W-1:0] mem_rdata
);

function automatic logic [ghb_pkg::DATA_W-1:0] swap16(input logic [ghb_pkg::DATA_W-1:0] d);
   swap16 = {d[7:0], d[15:8]};
endfunction

////////////////////////////////////////////////////////////////////////////////
// host bus clock domain

logic cs_n_r;
logic wr_lo_n_r;
logic wr_hi_n_r;
logic rd_lo_n_r;
logic rd_hi_n_r;
logic [ghb_pkg::ADDR_W-1:0] addr_r;
logic [ghb_pkg::DATA_W-1:0] din_r;
logic gen_s1_r;
logic gen_s2_r;
logic ack_s1_r;
logic ack_s2_r;
logic ack_s3_r;
logic ack_seen;
logic any_wr;
logic any_rd;
logic go;
ghb_pkg::ghb_hstate_t hs_r;
ghb_pkg::ghb_hstate_t hs_nxt;
ghb_pkg::ghb_xfer_t hold_r;
ghb_pkg::ghb_xfer_t hold_nxt;
logic req_tgl_r;
logic req_tgl_nxt;
logic wait_n_r;
logic wait_n_nxt;
logic oe_n_r;
logic oe_n_nxt;
logic [ghb_pkg::DATA_W-1:0] dout_r;
logic [ghb_pkg::DATA_W-1:0] dout_nxt;
// core side, declared here because the host reads them, rdata_r only after the ack
logic ack_tgl_r;
logic [ghb_pkg::DATA_W-1:0] rdata_r;
ghb_pkg::ghb_cfg_t cfg_r;
logic cfg_valid_r;

// pins are timed to the host bus clock, one stage for timing only
always_ff @(posedge host_if_clock or posedge sys_rst) begin // R15
   if (sys_rst) begin
      cs_n_r <= 1'h1;
      wr_lo_n_r <= 1'h1;
      wr_hi_n_r <= 1'h1;
      rd_lo_n_r <= 1'h1;
      rd_hi_n_r <= 1'h1;
      addr_r <= '0;
      din_r <= '0;
      gen_s1_r <= 1'h0;
      gen_s2_r <= 1'h0;
      ack_s1_r <= 1'h0;
      ack_s2_r <= 1'h0;
      ack_s3_r <= 1'h0;
   end else begin
      cs_n_r <= cs_n;
      wr_lo_n_r <= low_byte_write_n;
      wr_hi_n_r <= high_byte_write_n;
      rd_lo_n_r <= low_byte_read_n;
      rd_hi_n_r <= high_byte_read_n;
      addr_r <= ctrl_address;
      din_r <= ctrl_data_in;
      gen_s1_r <= cfg_valid_r && cfg_r.generic1;
      gen_s2_r <= gen_s1_r;
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
   end
end

assign ack_seen = ack_s2_r ^ ack_s3_r;
assign any_wr = !wr_lo_n_r || !wr_hi_n_r; // R17
assign any_rd = !rd_lo_n_r || !rd_hi_n_r; // R18
// pins stay dead until the general mode was strapped
assign go = gen_s2_r && !cs_n_r && (any_wr || any_rd); // R11 R16

always_comb begin
   hs_nxt = hs_r;
   hold_nxt = hold_r;
   req_tgl_nxt = req_tgl_r;
   wait_n_nxt = wait_n_r;
   oe_n_nxt = oe_n_r;
   dout_nxt = dout_r;
   case (hs_r)
      ghb_pkg::H_IDLE: begin
         // wait idles low so the inverted host ack stays quiet
         wait_n_nxt = 1'h0;
         oe_n_nxt = 1'h1;
         if (go) begin
            hold_nxt.write = any_wr;
            // bit zero stays a plain address bit, lanes come from strobes
            hold_nxt.be = any_wr ? {!wr_hi_n_r, !wr_lo_n_r}
                                 : {!rd_hi_n_r, !rd_lo_n_r}; // R14
            hold_nxt.addr = addr_r; // R14
            hold_nxt.wdata = din_r;
            req_tgl_nxt = !req_tgl_r;
            hs_nxt = ghb_pkg::H_BUSY;
         end
      end
      ghb_pkg::H_BUSY: begin
         if (ack_seen) begin
            dout_nxt = rdata_r;
            wait_n_nxt = 1'h1; // R19 R05
            oe_n_nxt = hold_r.write;
            hs_nxt = ghb_pkg::H_DONE;
         end
      end
      ghb_pkg::H_DONE: begin
         if (cs_n_r || !(any_wr || any_rd)) begin
            wait_n_nxt = 1'h0;
            oe_n_nxt = 1'h1;
            hs_nxt = ghb_pkg::H_IDLE;
         end
      end
      default: begin
         hs_nxt = ghb_pkg::H_IDLE;
      end
   endcase
end

always_ff @(posedge host_if_clock or posedge sys_rst) begin
   if (sys_rst) begin
      hs_r <= ghb_pkg::H_IDLE;
      hold_r <= '0;
      req_tgl_r <= 1'h0;
      wait_n_r <= 1'h0;
      oe_n_r <= 1'h1;
      dout_r <= '0;
   end else begin
      hs_r <= hs_nxt;
      hold_r <= hold_nxt;
      req_tgl_r <= req_tgl_nxt;
      wait_n_r <= wait_n_nxt;
      oe_n_r <= oe_n_nxt;
      dout_r <= dout_nxt;
   end
end

assign ctrl_data_out = dout_r;
assign ctrl_data_oe_n = oe_n_r;
assign wait_n = wait_n_r;

wait_busy_a: assert property (@(posedge host_if_clock) disable iff (sys_rst) // R19
   hs_r == ghb_pkg::H_BUSY |-> !wait_n_r) else $error("wait released while busy");
wait_cause_a: assert property (@(posedge host_if_clock) disable iff (sys_rst) // R05
   $rose(wait_n_r) |-> $past(ack_seen) && $past(hs_r) == ghb_pkg::H_BUSY)
   else $error("wait released without core answer");
read_drive_a: assert property (@(posedge host_if_clock) disable iff (sys_rst) // R19
   !oe_n_r |-> wait_n_r && !hold_r.write) else $error("data driven too early");
start_take_a: assert property (@(posedge host_if_clock) disable iff (sys_rst) // R14
   hs_r == ghb_pkg::H_IDLE && go |=> hs_r == ghb_pkg::H_BUSY
   && req_tgl_r != $past(req_tgl_r)) else $error("access not taken");
byte_lane_a: assert property (@(posedge host_if_clock) disable iff (sys_rst) // R17
   hs_r == ghb_pkg::H_IDLE && go && any_wr |=> hold_r.write
   && hold_r.be == {!$past(wr_hi_n_r), !$past(wr_lo_n_r)}) else $error("write lanes wrong");
mode_gate_a: assert property (@(posedge host_if_clock) disable iff (sys_rst) // R11
   !gen_s2_r |=> hs_r == ghb_pkg::H_IDLE) else $error("access before mode set");

////////////////////////////////////////////////////////////////////////////////
// main clock domain

logic req_s1_r;
logic req_s2_r;
logic req_s3_r;
logic req_seen;
logic [5:0] strap_s1_r;
logic [5:0] strap_s2_r;
logic [1:0] strap_cnt_r;
logic [1:0] strap_cnt_nxt;
ghb_pkg::ghb_cfg_t cfg_nxt;
logic cfg_valid_nxt;
logic pwr_r;
logic pwr_nxt;
ghb_pkg::ghb_cstate_t cs_r;
ghb_pkg::ghb_cstate_t cs_nxt;
ghb_pkg::ghb_xfer_t xfer_r;
ghb_pkg::ghb_xfer_t xfer_nxt;
logic mreq_r;
logic mreq_nxt;
logic is_reg_r;
logic is_reg_nxt;
logic ack_tgl_nxt;
logic [ghb_pkg::DATA_W-1:0] rdata_nxt;

always_ff @(posedge clock or posedge sys_rst) begin
   if (sys_rst) begin
      req_s1_r <= 1'h0;
      req_s2_r <= 1'h0;
      req_s3_r <= 1'h0;
      strap_s1_r <= '0;
      strap_s2_r <= '0;
   end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      strap_s1_r <= {bus_mode_straps, bus_status_n, endian_and_power_straps};
      strap_s2_r <= strap_s1_r;
   end
end

assign req_seen = req_s2_r ^ req_s3_r;

// straps are taken once the synchroniser has filled after release
always_comb begin
   strap_cnt_nxt = strap_cnt_r;
   cfg_nxt = cfg_r;
   cfg_valid_nxt = cfg_valid_r;
   if (!cfg_valid_r) begin
      if (strap_cnt_r == ghb_pkg::STRAP_SETTLE) begin
         cfg_nxt.mode = strap_s2_r[ghb_pkg::STRAP_MODE +: ghb_pkg::MODE_W]; // R11 R13
         cfg_nxt.bus_status_n = strap_s2_r[ghb_pkg::STRAP_STATUS]; // R11
         cfg_nxt.generic1 = strap_s2_r[ghb_pkg::STRAP_MODE +: ghb_pkg::MODE_W] == ghb_pkg::MODE_GEN
            && strap_s2_r[ghb_pkg::STRAP_STATUS] == ghb_pkg::STATUS_GEN1; // R20
         cfg_nxt.big_endian = strap_s2_r[ghb_pkg::STRAP_ENDIAN]; // R12
         cfg_nxt.power_high = strap_s2_r[ghb_pkg::STRAP_POWER]; // R12
         cfg_valid_nxt = 1'h1;
      end else begin
         strap_cnt_nxt = strap_cnt_r + 2'h1;
      end
   end
   // panel power output stays low until its polarity is known
   pwr_nxt = cfg_valid_r && (cfg_r.power_high ? panel_power_on : !panel_power_on); // R12
end

always_ff @(posedge clock or posedge sys_rst) begin
   if (sys_rst) begin
      strap_cnt_r <= 2'h0;
      cfg_r <= '0;
      cfg_valid_r <= 1'h0;
      pwr_r <= 1'h0;
   end else begin
      strap_cnt_r <= strap_cnt_nxt;
      cfg_r <= cfg_nxt;
      cfg_valid_r <= cfg_valid_nxt;
      pwr_r <= pwr_nxt;
   end
end

// hold_r is stable from the toggle until the ack returns, so it is safe here
always_comb begin
   cs_nxt = cs_r;
   xfer_nxt = xfer_r;
   mreq_nxt = mreq_r;
   is_reg_nxt = is_reg_r;
   ack_tgl_nxt = ack_tgl_r;
   rdata_nxt = rdata_r;
   case (cs_r)
      ghb_pkg::C_IDLE: begin
         if (req_seen) begin
            xfer_nxt = hold_r;
            if (cfg_r.big_endian) begin
               xfer_nxt.wdata = swap16(hold_r.wdata); // R21
               xfer_nxt.be = {hold_r.be[0], hold_r.be[1]};
            end
            is_reg_nxt = &hold_r.addr[ghb_pkg::ADDR_W-1:ghb_pkg::REG_LSB]; // R23
            mreq_nxt = 1'h1;
            cs_nxt = ghb_pkg::C_REQ;
         end
      end
      ghb_pkg::C_REQ: begin
         // refresh arbitration decides when the grant comes
         if (mem_gnt) begin
            rdata_nxt = cfg_r.big_endian ? swap16(mem_rdata) : mem_rdata; // R21
            ack_tgl_nxt = !ack_tgl_r; // R19
            mreq_nxt = 1'h0;
            cs_nxt = ghb_pkg::C_IDLE;
         end
      end
      default: begin
         cs_nxt = ghb_pkg::C_IDLE;
      end
   endcase
end

always_ff @(posedge clock or posedge sys_rst) begin
   if (sys_rst) begin
      cs_r <= ghb_pkg::C_IDLE;
      xfer_r <= '0;
      mreq_r <= 1'h0;
      is_reg_r <= 1'h0;
      ack_tgl_r <= 1'h0;
      rdata_r <= '0;
   end else begin
      cs_r <= cs_nxt;
      xfer_r <= xfer_nxt;
      mreq_r <= mreq_nxt;
      is_reg_r <= is_reg_nxt;
      ack_tgl_r <= ack_tgl_nxt;
      rdata_r <= rdata_nxt;
   end
end

assign cfg = cfg_r;
assign cfg_valid = cfg_valid_r;
assign panel_power_out = pwr_r;
assign mem_xfer = xfer_r;
assign mem_req = mreq_r;
assign mem_is_reg = is_reg_r;

req_hold_a: assert property (@(posedge clock) disable iff (sys_rst) // R19
   mreq_r && !mem_gnt |=> mreq_r && $stable(xfer_r)) else $error("request dropped early");
reg_window_a: assert property (@(posedge clock) disable iff (sys_rst) // R23
   mreq_r |-> is_reg_r == (&xfer_r.addr[ghb_pkg::ADDR_W-1:ghb_pkg::REG_LSB]))
   else $error("register window decode wrong");
strap_keep_a: assert property (@(posedge clock) disable iff (sys_rst) // R12
   cfg_valid_r && $past(cfg_valid_r) |-> $stable(cfg_r)) else $error("straps changed");
gen_decode_a: assert property (@(posedge clock) disable iff (sys_rst) // R11
   cfg_valid_r |-> cfg_r.generic1 == (cfg_r.mode == ghb_pkg::MODE_GEN
   && cfg_r.bus_status_n == ghb_pkg::STATUS_GEN1)) else $error("mode decode wrong");
power_pol_a: assert property (@(posedge clock) disable iff (sys_rst) // R12
   cfg_valid_r |=> pwr_r == ($past(cfg_r.power_high) ? $past(panel_power_on)
   : !$past(panel_power_on))) else $error("panel power polarity wrong");
ack_once_a: assert property (@(posedge clock) disable iff (sys_rst) // R05
   mreq_r && mem_gnt |=> !mreq_r && ack_tgl_r != $past(ack_tgl_r))
   else $error("grant not answered");

endmodule

// File: ghb_host_if_bench.sv
`timescale 1ns/1ns
module ghb_host_if_bench;
   logic clock, sys_rst, host_if_clock, oe_n, wait_n, cs_n, stat_n, pwr_on, pwr_out;
   logic [15:0] bus, dout, h_addr, h_data, mem_rdata;
   logic [1:0] wr_n, rd_n, ep_s;
   logic [2:0] mode_s;
   logic cfg_valid, mem_req, mem_is_reg, got_reg, mem_gnt;
   ghb_pkg::ghb_cfg_t cfg;
   ghb_pkg::ghb_xfer_t mx, got;
   int n_fail, num_checks, n_gnt, seed;
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      host_if_clock = 1'b0;
      #37;
      forever #80 host_if_clock = ~host_if_clock;
   end
   assign bus = oe_n ? h_data : dout;
   ghb_host_if dut_u (.clock(clock), .sys_rst(sys_rst), .host_if_clock(host_if_clock),
      .cs_n(cs_n), .ctrl_address(h_addr), .ctrl_data_in(bus), .ctrl_data_out(dout),
      .ctrl_data_oe_n(oe_n), .low_byte_write_n(wr_n[0]), .high_byte_write_n(wr_n[1]),
      .low_byte_read_n(rd_n[0]), .high_byte_read_n(rd_n[1]), .wait_n(wait_n),
      .bus_mode_straps(mode_s), .bus_status_n(stat_n), .endian_and_power_straps(ep_s),
      .panel_power_on(pwr_on), .panel_power_out(pwr_out), .cfg(cfg),
      .cfg_valid(cfg_valid), .mem_xfer(mx), .mem_req(mem_req), .mem_is_reg(mem_is_reg),
      .mem_gnt(mem_gnt), .mem_rdata(mem_rdata));
   ghb_host_model hm_u (.host_if_clock(host_if_clock), .wait_n(wait_n), .bus_in(bus),
      .cs_n(cs_n), .addr(h_addr), .data(h_data), .wr_n(wr_n), .rd_n(rd_n),
      .transfer_ack_n());
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rd_word(input logic [15:0] a);
      return a ^ 16'h5a3c;
   endfunction
   function automatic logic [15:0] sw(input logic [15:0] v, input logic b);
      return b ? {v[7:0], v[15:8]} : v;
   endfunction
   // arbiter stalls at random so the wait path sees varied latency
   always @(posedge clock) begin
      mem_gnt <= 1'b0;
      if (mem_req && !mem_gnt && ($random(seed) & 3) == 0) begin
         mem_gnt <= 1'b1;
         mem_rdata <= rd_word(mx.addr);
         got <= mx;
         got_reg <= mem_is_reg;
         n_gnt <= n_gnt + 1;
      end
   end
   task automatic chk(input logic [39:0] g, input logic [39:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic finish_test();
      $display("checks=%0d fails=%0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic do_reset(input logic big, input logic pw);
      sys_rst <= 1'b1;
      ep_s <= {pw, big};
      repeat (20) @(posedge clock);
      // host domain gets one edge of its own under reset
      @(posedge host_if_clock);
      @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge host_if_clock);
   endtask
   task automatic one(input logic wr, input logic [1:0] be, input logic [15:0] a,
         input logic [15:0] d, input logic big);
      logic [15:0] q, m;
      logic ok;
      ghb_pkg::ghb_xfer_t e, gc;
      int g0, a0;
      g0 = n_gnt;
      a0 = hm_u.n_ack;
      hm_u.access(wr, be, a, d, q, ok);
      gc = got;
      if (!wr) gc.wdata = 16'h0;
      e.write = wr;
      e.be = big ? {be[0], be[1]} : be;
      e.addr = a;
      e.wdata = wr ? sw(d, big) : 16'h0;
      m = {{8{be[1]}}, {8{be[0]}}};
      chk(40'(ok), 40'h1);
      chk(40'(gc), 40'(e));
      chk(40'(got_reg), 40'(&a[15:5]));
      chk(40'(n_gnt - g0), 40'h1);
      if (!wr) chk(40'(q & m), 40'(sw(rd_word(a), big) & m));
      if (wr) chk(40'(q), 40'(d));
      chk(40'(hm_u.n_ack - a0), 40'h1);
      chk(40'(wait_n), 40'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] r;
      logic [15:0] a;
      int g;
      logic ok;
      seed = 32'h2243;
      sys_rst = 1'b1;
      mode_s = ghb_pkg::MODE_GEN;
      stat_n = ghb_pkg::STATUS_GEN1;
      ep_s = 2'h0;
      pwr_on = 1'b0;
      mem_gnt = 1'b0;
      mem_rdata = 16'h0;
      n_gnt = 0;
      for (int p = 0; p < 2; p++) begin
         do_reset(p[0], ~p[0]);
         chk(40'(cfg_valid), 40'h1);
         chk(40'(cfg.mode), 40'(ghb_pkg::MODE_GEN));
         chk(40'(cfg.generic1), 40'h1);
         chk(40'(cfg.big_endian), 40'(p[0]));
         chk(40'({cfg.bus_status_n, cfg.power_high}), 40'({ghb_pkg::STATUS_GEN1, ~p[0]}));
         for (int v = 0; v < 2; v++) begin
            @(posedge clock);
            pwr_on <= v[0];
            repeat (4) @(posedge clock);
            chk(40'(pwr_out), 40'(v[0] ^ p[0]));
         end
         g = n_gnt;
         hm_u.stray();
         repeat (3) @(posedge host_if_clock);
         chk(40'(n_gnt - g), 40'h0);
         chk(40'(wait_n), 40'h0);
         for (int k = 0; k < 24; k++) begin
            r = $random(seed);
            a = r[15:0];
            if (k < 3) a = (k == 0) ? 16'hffdf : (k == 1) ? 16'hffe0 : 16'h0;
            else if (k[0]) a[15:5] = 11'h7ff;
            if (r[17:16] == 2'h0) r[17:16] = 2'h3;
            one(r[18], r[17:16], a, r[31:16] ^ r[15:0], p[0]);
         end
      end
      // strapped for the other generic mode: pins must stay dead
      stat_n <= !ghb_pkg::STATUS_GEN1;
      do_reset(1'b0, 1'b1);
      chk(40'({cfg_valid, cfg.generic1}), 40'h2);
      g = n_gnt;
      hm_u.access(1'b0, 2'h3, 16'h0, 16'h0, a, ok);
      chk(40'({ok, wait_n}), 40'h0);
      chk(40'(n_gnt - g), 40'h0);
      finish_test();
   end
   initial begin
      #400000;
      n_fail++;
      finish_test();
   end
endmodule

// File: ghb_host_model.sv
`timescale 1ns/1ns
module ghb_host_model (
   input wire logic host_if_clock,
   input wire logic wait_n,
   input wire logic [15:0] bus_in,
   output logic cs_n,
   output logic [15:0] addr,
   output logic [15:0] data,
   output logic [1:0] wr_n,
   output logic [1:0] rd_n,
   output logic transfer_ack_n
);
   int n_ack;
   // io select decode: base and slot are arbitrary, the 64K block shadows the 2M window
   localparam logic [7:0] CS_BASE = 8'h40;
   localparam logic [2:0] CS_SLOT = 3'h4;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   initial begin
      cs_n = 1'b1;
      wr_n = 2'h3;
      rd_n = 2'h3;
      addr = 16'h0;
      data = 16'h0;
      transfer_ack_n = 1'b1;
      n_ack = 0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // single cycles only: this chip select never bursts
   task automatic access(input logic wr, input logic [1:0] be, input logic [15:0] a,
         input logic [15:0] d, output logic [15:0] q, output logic ok);
      int n;
      logic [31:0] ha;
      logic [1:0] size_code;
      logic [1:0] lanes;
      @(posedge host_if_clock);
      ha = {CS_BASE, CS_SLOT, 5'h0, a};
      // port width is 16 bits, so a two-lane access is one word cycle
      size_code = (be == 2'h3) ? SIZE_WORD : SIZE_BYTE;
      lanes = (size_code == SIZE_WORD) ? 2'h3 : be;
      cs_n <= (ha[31:21] != {CS_BASE, CS_SLOT});
      addr <= a;
      data <= wr ? d : ~data;
      wr_n <= wr ? ~lanes : 2'h3;
      rd_n <= wr ? 2'h3 : ~lanes;
      ok = 1'b0;
      n = 0;
      // external acknowledge only: no internal wait states are counted
      while (!ok && n < 400) begin
         @(posedge host_if_clock);
         ok = (wait_n === 1'b1);
         n++;
      end
      q = bus_in;
      transfer_ack_n <= ~ok;
      cs_n <= 1'b1;
      wr_n <= 2'h3;
      rd_n <= 2'h3;
      addr <= ~a;
      data <= ~d;
      @(posedge host_if_clock);
      transfer_ack_n <= 1'b1;
      n_ack += int'(ok);
      n = 0;
      // no new cycle while the ready is still up
      while (wait_n !== 1'b0 && n < 8) begin
         @(posedge host_if_clock);
         n++;
      end
   endtask
   // read strobes with no chip select: the device must ignore them
   task automatic stray();
      @(posedge host_if_clock);
      rd_n <= 2'h0;
      repeat (4) @(posedge host_if_clock);
      rd_n <= 2'h3;
   endtask
endmodule

// File: ghb_pkg.sv
// Summary of operation
// R01: Host starts a transfer with full address and a one-clock start strobe.
// R02: Host drives a size code marking each cycle as 8, 16 or 32 bits.
// R03: Host direction signal is high for reads and low for writes.
// R04: Host holds transfer-in-progress asserted while any bus cycle is active.
// R05: Finished transfer gives a one-clock low acknowledge that ends the transaction.
// R06: Host starts no new cycle until the acknowledge is released.
// R07: Every host transaction lasts at least two bus clocks.
// R08: Bursts are four 32-bit transfers; disabled on this chip select.
// R09: Host chip selects configure width, 0-15 waits, space type, burst, protection.
// R10: Six IO chip selects each decode a fixed 2M block from one base.
// R11: Mode straps and bus status are caught at reset release, then pins take function.
// R12: Endian and panel power polarity straps are also caught at reset.
// R13: One 16-bit host interface with six selectable bus protocol modes; this code serves only the general mode with bus status low.
// R14: General mode: address bit zero is plain, per-byte read and write strobes.
// R15: Host interface runs on its own bus clock, apart from the main clock.
// R16: External logic decodes high host address lines into the active-low chip select.
// R17: External logic drives per-byte write strobes low while the host writes.
// R18: External logic drives per-byte read strobes low while the host reads.
// R19: Wait output stays low until read data is valid or write data taken.
// R20: Bus status pin is unused in general mode and tied low to select it.
// R21: A 32-bit big endian host uses high data lines and sets the endian strap.
// R22: Glue inverts wait into the host acknowledge, enabled only under chip select.
// R23: Display buffer starts the 64K block; registers are its final 32 bytes.
// R24: Host chip select has burst reads and automatic acknowledge turned off.
// R25: A host-clock bridge turns each wait release into one single-cycle acknowledge.
package ghb_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int MODE_W = 3;
   // register window: address bits from this one up are all ones
   localparam int REG_LSB = 5;
   localparam logic [MODE_W-1:0] MODE_ALT0 = 3'h0;
   localparam logic [MODE_W-1:0] MODE_ALT1 = 3'h1;
   localparam logic [MODE_W-1:0] MODE_ALT3 = 3'h3;
   localparam logic [MODE_W-1:0] MODE_ALT5 = 3'h5;
   localparam logic [MODE_W-1:0] MODE_GEN = 3'h7;
   localparam logic STATUS_GEN1 = 1'h0;
   localparam int STRAP_ENDIAN = 0;
   localparam int STRAP_POWER = 1;
   localparam int STRAP_STATUS = 2;
   localparam int STRAP_MODE = 3;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   typedef enum logic [1:0] {
      H_IDLE = 2'h0,
      H_BUSY = 2'h1,
      H_DONE = 2'h3
   } ghb_hstate_t;
   typedef enum logic {
      C_IDLE = 1'h0,
      C_REQ = 1'h1
   } ghb_cstate_t;
   typedef struct packed {
      logic write;
      logic [1:0] be;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ghb_xfer_t;
   typedef struct packed {
      logic [MODE_W-1:0] mode;
      logic bus_status_n;
      logic generic1;
      logic big_endian;
      logic power_high;
   } ghb_cfg_t;
endpackage
